// ### ipt_defines.svh
// offsets, reset values, field positions and timing figures of the i2c port timing block
`ifndef IPT_DEFINES_SVH
`define IPT_DEFINES_SVH

// register offsets
`define IPT_OFF_CTRL1 8'h08
`define IPT_OFF_CTRL2 8'h09
`define IPT_OFF_HIGH 8'h0a
`define IPT_OFF_LOW 8'h0b

// reset values
`define IPT_RST_CTRL1 8'h1c
`define IPT_RST_CTRL2 8'h10
`define IPT_RST_HIGH 8'h79
`define IPT_RST_LOW 8'h79
`define IPT_RD_ZERO 8'h00

// field positions
`define IPT_WBLK_BIT 7
`define IPT_HOLD_MSB 6
`define IPT_HOLD_LSB 4
`define IPT_FILT_MSB 3
`define IPT_FILT_LSB 0
`define IPT_SETUP_MSB 7
`define IPT_SETUP_LSB 4
`define IPT_DELAY_MSB 3
`define IPT_DELAY_LSB 2
`define IPT_FAST_BIT 1
`define IPT_WDDIS_BIT 0

// timing figures
`define IPT_CLK_NS 20
`define IPT_CLK_MHZ 50
`define IPT_CLK_HZ 50000000
`define IPT_HOLD_UNIT_NS 50
`define IPT_FILT_UNIT_NS 5
`define IPT_SETUP_BASE_NS 80
`define IPT_SETUP_UNIT_NS 640
`define IPT_DELAY_BASE_NS 240
`define IPT_DELAY_UNIT_NS 40
`define IPT_OSC_NS 40
`define IPT_OSC_DIV (`IPT_OSC_NS / `IPT_CLK_NS)
`define IPT_OSC_EXTRA 5
`define IPT_RECOV_PULSES 9
`define IPT_WD_SLOW_S 1
`define IPT_WD_FAST_US 50
`define IPT_WD_FAST_CYC (`IPT_WD_FAST_US * `IPT_CLK_MHZ)
`define IPT_HOLD_TAPS 18

`endif

// ### ipt_pkg.sv
// types of the i2c port timing block
package ipt_pkg;

   // controller clock engine, gray along idle-low-high
   typedef enum logic [1:0]
   {
      IPT_IDLE = 2'b00,
      IPT_LOW = 2'b01,
      IPT_HIGH = 2'b11
   } ipt_fsm_e;

   // whole state of the block
   typedef struct packed
   {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] high;
      logic [7:0] low;
      logic [7:0] sh_ctrl1;
      logic [7:0] sh_ctrl2;
      logic [7:0] sh_high;
      logic [7:0] sh_low;
      logic osc_ph;
      logic scl_f;
      logic sda_f;
      logic [2:0] fcnt_scl;
      logic [2:0] fcnt_sda;
      logic [17:0] sda_dly;
      logic sda_held;
      logic [25:0] wd_cnt;
      logic bus_free;
      ipt_fsm_e st;
      logic [8:0] tcnt;
      logic [3:0] pulses;
      logic recov;
      logic ctl_done;
      logic scl_ctl;
      logic str_act;
      logic [9:0] str_cnt;
      logic [4:0] sda_cnt;
      logic sda_pend;
      logic sda_oe;
      logic scl_oe;
      logic [7:0] rd_data;
      logic wr_blocked;
      logic fwd_go;
   } ipt_state_s;

endpackage

// ### ipt_port_timing.sv
// i2c port timing: filter, hold, output timing, bus watchdog and controller clock
//
// Operation
// - a write from across the control channel to a local register is dropped while the block bit is set.
// - forwarded accesses to targets behind this port pass whatever the block bit says.
// - the sda input is held internally for the hold field times 50 ns relative to scl.
// - pulses on scl and sda no wider than the filter field times 5 ns are rejected.
// - in remote ack cycles sda leads the scl rise by 80 ns plus 640 ns per setup count.
// - sda changes follow the scl fall by 240 ns plus 40 ns per delay code.
// - the bus watchdog expires after about 1 s of quiet, or about 50 us with the fast bit set.
// - the watchdog disable bit stops the watchdog, and at reset the watchdog runs.
// - on expiry with sda high the bus is taken to be free.
// - on expiry with sda low the block drives 9 clock pulses on scl to clear the bus, or 1 if a controller clock request comes in the same cycle.
// - as controller scl stays high for the high count plus 5 oscillator periods.
// - as controller scl stays low for the low count plus 5 oscillator periods.
// - as target the low count plus 5 periods is the sda setup before a stretched scl is let go.
// - the reset counts give at least 5 us high and low with a 25 MHz plus 100 ppm reference.
`timescale 1ns/1ps

`include "ipt_defines.svh"

module ipt_port_timing
   import ipt_pkg::*;
#(
   parameter int unsigned WD_SLOW_CYC = `IPT_WD_SLOW_S * `IPT_CLK_HZ
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_remote,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_wr_blocked,
   // forwarded target access
   input wire logic fwd_req,
   output logic fwd_go,
   // target side requests
   input wire logic tgt_sda_low,
   input wire logic tgt_stretch,
   input wire logic tgt_remote_ack,
   // controller clock request
   input wire logic ctl_pulse_req,
   output logic ctl_done,
   // bus state
   output logic bus_free,
   output logic bus_recovering,
   output logic scl_filt,
   output logic sda_held,
   // scl pin, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   // sda pin, open drain
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);

   localparam ipt_state_s RST_STATE = '{
      ctrl1: `IPT_RST_CTRL1,
      ctrl2: `IPT_RST_CTRL2,
      high: `IPT_RST_HIGH,
      low: `IPT_RST_LOW,
      sh_ctrl1: `IPT_RST_CTRL1,
      sh_ctrl2: `IPT_RST_CTRL2,
      sh_high: `IPT_RST_HIGH,
      sh_low: `IPT_RST_LOW,
      osc_ph: 1'b0,
      scl_f: 1'b1,
      sda_f: 1'b1,
      fcnt_scl: 3'h0,
      fcnt_sda: 3'h0,
      sda_dly: 18'h3ffff,
      sda_held: 1'b1,
      wd_cnt: 26'h0,
      bus_free: 1'b0,
      st: IPT_IDLE,
      tcnt: 9'h0,
      pulses: 4'h0,
      recov: 1'b0,
      ctl_done: 1'b0,
      scl_ctl: 1'b0,
      str_act: 1'b0,
      str_cnt: 10'h0,
      sda_cnt: 5'h0,
      sda_pend: 1'b0,
      sda_oe: 1'b0,
      scl_oe: 1'b0,
      rd_data: `IPT_RD_ZERO,
      wr_blocked: 1'b0,
      fwd_go: 1'b0
   };

   ipt_state_s s;
   ipt_state_s next_s;

   // derived counts from the shadowed fields
   logic osc_tick;
   logic [2:0] filt_lim;
   logic [4:0] hold_cyc;
   logic [9:0] setup_cyc;
   logic [4:0] delay_cyc;
   logic [9:0] lowset_cyc;
   logic [8:0] hi_ticks;
   logic [8:0] lo_ticks;
   logic [25:0] wd_lim;
   logic activity;
   logic scl_fall;
   // filtered inputs, declared ahead of the counts process that reads them for edge detection
   logic next_scl_f_w;
   logic next_sda_f_w;
   logic [2:0] next_fcnt_scl_w;
   logic [2:0] next_fcnt_sda_w;

   // counts rounded up to whole cycles, all from shadow copies
   always_comb
   begin
      int t;
      t = 0;
      osc_tick = s.osc_ph;
      t = (int'(s.sh_ctrl1[`IPT_FILT_MSB:`IPT_FILT_LSB]) * `IPT_FILT_UNIT_NS + `IPT_CLK_NS - 1) / `IPT_CLK_NS;
      filt_lim = 3'(t);
      t = (int'(s.sh_ctrl1[`IPT_HOLD_MSB:`IPT_HOLD_LSB]) * `IPT_HOLD_UNIT_NS + `IPT_CLK_NS - 1) / `IPT_CLK_NS;
      hold_cyc = 5'(t);
      t = `IPT_SETUP_BASE_NS + int'(s.sh_ctrl2[`IPT_SETUP_MSB:`IPT_SETUP_LSB]) * `IPT_SETUP_UNIT_NS;
      setup_cyc = 10'((t + `IPT_CLK_NS - 1) / `IPT_CLK_NS);
      t = `IPT_DELAY_BASE_NS + int'(s.sh_ctrl2[`IPT_DELAY_MSB:`IPT_DELAY_LSB]) * `IPT_DELAY_UNIT_NS;
      delay_cyc = 5'((t + `IPT_CLK_NS - 1) / `IPT_CLK_NS);
      hi_ticks = 9'(int'(s.sh_high) + `IPT_OSC_EXTRA);
      lo_ticks = 9'(int'(s.sh_low) + `IPT_OSC_EXTRA);
      lowset_cyc = 10'(int'(lo_ticks) * `IPT_OSC_DIV);
      if (s.sh_ctrl2[`IPT_FAST_BIT])
      begin
         wd_lim = 26'(`IPT_WD_FAST_CYC);
      end
      else
      begin
         wd_lim = 26'(WD_SLOW_CYC);
      end
      activity = (next_scl_f_w != s.scl_f) || (next_sda_f_w != s.sda_f);
      scl_fall = s.scl_f && !next_scl_f_w;
   end

   // glitch reject, input must outlast the filter width
   always_comb
   begin
      next_scl_f_w = s.scl_f;
      next_sda_f_w = s.sda_f;
      next_fcnt_scl_w = 3'h0;
      next_fcnt_sda_w = 3'h0;
      if (scl_in != s.scl_f)
      begin
         if (s.fcnt_scl >= filt_lim)
         begin
            next_scl_f_w = scl_in;
         end
         else
         begin
            next_fcnt_scl_w = s.fcnt_scl + 3'h1;
         end
      end
      if (sda_in != s.sda_f)
      begin
         if (s.fcnt_sda >= filt_lim)
         begin
            next_sda_f_w = sda_in;
         end
         else
         begin
            next_fcnt_sda_w = s.fcnt_sda + 3'h1;
         end
      end
   end

   // main next-state logic
   always_comb
   begin
      next_s = s;
      next_s.osc_ph = !s.osc_ph;
      next_s.ctl_done = 1'b0;
      next_s.wr_blocked = 1'b0;
      next_s.scl_f = next_scl_f_w;
      next_s.sda_f = next_sda_f_w;
      next_s.fcnt_scl = next_fcnt_scl_w;
      next_s.fcnt_sda = next_fcnt_sda_w;

      // register writes
      if (reg_wr)
      begin
         if (reg_remote && s.ctrl1[`IPT_WBLK_BIT])
         begin
            next_s.wr_blocked = 1'b1;
         end
         else
         begin
            unique case (reg_addr)
               `IPT_OFF_CTRL1: next_s.ctrl1 = reg_wdata;
               `IPT_OFF_CTRL2: next_s.ctrl2 = reg_wdata;
               `IPT_OFF_HIGH: next_s.high = reg_wdata;
               `IPT_OFF_LOW: next_s.low = reg_wdata;
               default: next_s.ctrl1 = s.ctrl1;
            endcase
         end
      end
      // register reads, unmapped reads zero
      if (reg_rd)
      begin
         unique case (reg_addr)
            `IPT_OFF_CTRL1: next_s.rd_data = s.ctrl1;
            `IPT_OFF_CTRL2: next_s.rd_data = s.ctrl2;
            `IPT_OFF_HIGH: next_s.rd_data = s.high;
            `IPT_OFF_LOW: next_s.rd_data = s.low;
            default: next_s.rd_data = `IPT_RD_ZERO;
         endcase
      end

      next_s.fwd_go = fwd_req;

      if (s.st == IPT_IDLE && !s.str_act && !s.sda_pend)
      begin
         next_s.sh_ctrl1 = s.ctrl1;
         next_s.sh_ctrl2 = s.ctrl2;
         next_s.sh_high = s.high;
         next_s.sh_low = s.low;
      end

      next_s.sda_dly = {s.sda_dly[`IPT_HOLD_TAPS - 2:0], s.sda_f};
      if (hold_cyc == 5'h0)
      begin
         next_s.sda_held = s.sda_f;
      end
      else
      begin
         next_s.sda_held = s.sda_dly[hold_cyc - 5'h1];
      end

      // watchdog held while disabled or busy
      if (s.sh_ctrl2[`IPT_WDDIS_BIT] || activity || s.st != IPT_IDLE)
      begin
         next_s.wd_cnt = 26'h0;
      end
      else if (s.wd_cnt >= wd_lim - 26'h1)
      begin
         next_s.wd_cnt = 26'h0;
         if (s.sda_f)
         begin
            // quiet with sda high, bus free
            next_s.bus_free = 1'b1;
         end
         else
         begin
            // sda stuck low, start 9 pulses
            next_s.recov = 1'b1;
            next_s.pulses = 4'(`IPT_RECOV_PULSES);
         end
      end
      else
      begin
         next_s.wd_cnt = s.wd_cnt + 26'h1;
      end
      if (activity)
      begin
         next_s.bus_free = 1'b0;
      end

      // controller clock engine, counts oscillator ticks
      unique case (s.st)
         IPT_IDLE:
         begin
            if (s.recov || ctl_pulse_req)
            begin
               if (!s.recov)
               begin
                  next_s.pulses = 4'h1;
               end
               next_s.st = IPT_LOW;
               next_s.scl_ctl = 1'b1;
               next_s.tcnt = lo_ticks;
            end
         end
         IPT_LOW:
         begin
            if (osc_tick)
            begin
               if (s.tcnt <= 9'h1)
               begin
                  next_s.st = IPT_HIGH;
                  next_s.scl_ctl = 1'b0;
                  next_s.tcnt = hi_ticks;
               end
               else
               begin
                  next_s.tcnt = s.tcnt - 9'h1;
               end
            end
         end
         IPT_HIGH:
         begin
            if (osc_tick)
            begin
               if (s.tcnt <= 9'h1)
               begin
                  if (s.pulses > 4'h1)
                  begin
                     next_s.pulses = s.pulses - 4'h1;
                     next_s.st = IPT_LOW;
                     next_s.scl_ctl = 1'b1;
                     next_s.tcnt = lo_ticks;
                  end
                  else
                  begin
                     next_s.pulses = 4'h0;
                     next_s.recov = 1'b0;
                     next_s.st = IPT_IDLE;
                     next_s.ctl_done = 1'b1;
                  end
               end
               else
               begin
                  next_s.tcnt = s.tcnt - 9'h1;
               end
            end
         end
         default:
         begin
            next_s.st = IPT_IDLE;
            next_s.scl_ctl = 1'b0;
         end
      endcase

      // target stretch: held while data is prepared, then setup counted
      if (!s.str_act)
      begin
         // preload, so a stretch request of a single cycle still gets its full setup
         next_s.str_cnt = tgt_remote_ack ? setup_cyc : lowset_cyc;
         if (tgt_stretch && !s.scl_f)
         begin
            next_s.str_act = 1'b1;
         end
      end
      else if (tgt_stretch)
      begin
         if (tgt_remote_ack)
         begin
            next_s.str_cnt = setup_cyc;
         end
         else
         begin
            next_s.str_cnt = lowset_cyc;
         end
      end
      else if (s.str_cnt <= 10'h1)
      begin
         next_s.str_act = 1'b0;
         next_s.str_cnt = 10'h0;
      end
      else
      begin
         next_s.str_cnt = s.str_cnt - 10'h1;
      end

      // sda change waits out the fall delay
      if (scl_fall)
      begin
         next_s.sda_pend = 1'b1;
         next_s.sda_cnt = delay_cyc;
      end
      else if (s.sda_pend)
      begin
         if (s.sda_cnt <= 5'h1)
         begin
            next_s.sda_pend = 1'b0;
            next_s.sda_oe = tgt_sda_low;
         end
         else
         begin
            next_s.sda_cnt = s.sda_cnt - 5'h1;
         end
      end
      // recovery must leave sda released
      if (s.recov)
      begin
         next_s.sda_oe = 1'b0;
      end

      next_s.scl_oe = next_s.scl_ctl || next_s.str_act;
   end

   // single state register, synchronous reset
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         s <= RST_STATE;
      end
      else
      begin
         s <= next_s;
      end
   end

   // outputs straight from the state register; open drain pins only pull low
   assign reg_rdata = s.rd_data;
   assign reg_wr_blocked = s.wr_blocked;
   assign fwd_go = s.fwd_go;
   assign ctl_done = s.ctl_done;
   assign bus_free = s.bus_free;
   assign bus_recovering = s.recov;
   assign scl_filt = s.scl_f;
   assign sda_held = s.sda_held;
   assign scl_out = 1'b0;
   assign scl_oe = s.scl_oe;
   assign sda_out = 1'b0;
   assign sda_oe = s.sda_oe;

endmodule // ipt_port_timing

// ### ipt_bus_model.sv
// open-drain local i2c bus with pull-ups and the other parties on it
`timescale 1ns/1ps
module ipt_bus_model
(
   // pull-downs of the block
   input wire logic dut_scl_oe,
   input wire logic dut_sda_oe,
   // pull-downs of other controllers and targets
   input wire logic ext_scl_low,
   input wire logic ext_sda_low,
   // resolved lines
   output logic scl_line,
   output logic sda_line
);
   // wired and, the pull-up wins once every party lets go
   assign scl_line = !(dut_scl_oe || ext_scl_low);
   assign sda_line = !(dut_sda_oe || ext_sda_low);
endmodule // ipt_bus_model

// ### ipt_port_timing_properties.sv
// port checks of the i2c port timing block
`timescale 1ns/1ps
module ipt_port_timing_properties
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // watched ports
   input wire logic reg_wr,
   input wire logic reg_remote,
   input wire logic reg_wr_blocked,
   input wire logic fwd_req,
   input wire logic fwd_go,
   input wire logic tgt_stretch,
   input wire logic ctl_done,
   input wire logic bus_free,
   input wire logic bus_recovering,
   input wire logic scl_filt,
   input wire logic sda_held,
   input wire logic scl_in,
   input wire logic scl_oe
);
   logic [9:0] oe_run;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   // scl low held by the block, stretches excluded since the target sets their length
   always_ff @(posedge core_clk)
   begin
      if (srst || !scl_oe || tgt_stretch)
         oe_run <= 10'h000;
      else if (oe_run != 10'h3ff)
         oe_run <= oe_run + 10'h001;
   end

   blk_cause_a: assert property (reg_wr_blocked |-> $past(reg_wr) && $past(reg_remote))
      else $error("drop pulse without remote write");
   fwd_pass_a: assert property (!$past(srst) |-> fwd_go == $past(fwd_req))
      else $error("forwarded access gated");
   filt_stable_a: assert property (
      $changed(scl_filt) |-> $past(scl_in) == scl_filt && $past(scl_in, 2) == scl_filt)
      else $error("filter passed a short pulse");
   free_sda_a: assert property ($rose(bus_free) |-> sda_held)
      else $error("bus free with sda low");
   free_clear_a: assert property ($changed(scl_filt) |-> ##[1:2] !bus_free)
      else $error("bus free kept over activity");
   recov_sda_a: assert property ($rose(bus_recovering) |-> !sda_held)
      else $error("recovery with sda high");
   recov_clk_a: assert property (bus_recovering |-> ##[0:600] (scl_oe || !bus_recovering))
      else $error("recovery drives no clock");
   low_bound_a: assert property (oe_run < 10'h212)
      else $error("scl held low too long");
   done_pulse_a: assert property (ctl_done |-> !scl_oe ##1 !ctl_done)
      else $error("done not a single cycle at scl high");
endmodule // ipt_port_timing_properties

bind ipt_port_timing ipt_port_timing_properties u_props
(
   .core_clk(core_clk), .srst(srst), .reg_wr(reg_wr), .reg_remote(reg_remote),
   .reg_wr_blocked(reg_wr_blocked), .fwd_req(fwd_req), .fwd_go(fwd_go), .tgt_stretch(tgt_stretch),
   .ctl_done(ctl_done), .bus_free(bus_free), .bus_recovering(bus_recovering), .scl_filt(scl_filt),
   .sda_held(sda_held), .scl_in(scl_in), .scl_oe(scl_oe)
);

// ### tb_i2c_port_timing_config.sv
// self-checking bench of the i2c port timing block
`timescale 1ns/1ps
module tb_i2c_port_timing_config;
   localparam int WD_SLOW = 200;
   logic core_clk, srst, reg_wr, reg_rd, reg_remote, fwd_req, tgt_sda_low, tgt_stretch, tgt_remote_ack;
   logic ctl_pulse_req, reg_wr_blocked, fwd_go, ctl_done, bus_free, bus_recovering, scl_filt, sda_held;
   logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, ext_scl, ext_sda, blk;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;

   // block under test, watchdog shortened to keep the run brief
   ipt_port_timing #(.WD_SLOW_CYC(WD_SLOW)) DUT
   (
      .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_remote(reg_remote), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_wr_blocked(reg_wr_blocked),
      .fwd_req(fwd_req), .fwd_go(fwd_go), .tgt_sda_low(tgt_sda_low), .tgt_stretch(tgt_stretch),
      .tgt_remote_ack(tgt_remote_ack), .ctl_pulse_req(ctl_pulse_req), .ctl_done(ctl_done), .bus_free(bus_free),
      .bus_recovering(bus_recovering), .scl_filt(scl_filt), .sda_held(sda_held), .scl_in(scl_in),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
   );
   // other parties on the local bus
   ipt_bus_model bus
   (
      .dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe), .ext_scl_low(ext_scl), .ext_sda_low(ext_sda),
      .scl_line(scl_in), .sda_line(sda_in)
   );
   // 50 mhz clock
   initial
   begin
      core_clk = 1'b0;
      forever
         #10 core_clk = !core_clk;
   end
   // hang guard, far above the expected run
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         $display("Error at %0t: timeout", $time);
         print_verdict();
      end
   end
   // inputs change 1 ns after the edge
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int lo, input int hi, input string what);
      n_tests++;
      if (got < lo || got > hi)
      begin
         num_errors++;
         $display("Error at %0t: %s %0d not in %0d..%0d", $time, what, got, lo, hi);
      end
   endtask
   // register write, the drop flag is caught the cycle after
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem);
      reg_addr = a;
      reg_wdata = d;
      reg_remote = rem;
      reg_wr = 1'b1;
      tick();
      reg_wr = 1'b0;
      reg_remote = 1'b0;
      blk = reg_wr_blocked;
      tick();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      reg_addr = a;
      reg_rd = 1'b1;
      tick();
      reg_rd = 1'b0;
      chk(reg_rdata, exp, what);
      tick();
   endtask
   // reset values, read back, unmapped offset
   task automatic t_regs();
      logic [7:0] rst_val [5];
      rst_val = '{8'h1c, 8'h10, 8'h79, 8'h79, 8'h00};
      for (int i = 0; i < 5; i++)
      begin
         rd(8'h08 + 8'(i), rst_val[i], "reset");
         wr(8'h08 + 8'(i), 8'h5a, 1'b0);
         rd(8'h08 + 8'(i), (i < 4) ? 8'h5a : 8'h00, "readback");
      end
   endtask
   // remote write block and forwarded accesses
   task automatic t_block();
      wr(8'h08, 8'h9c, 1'b0);
      wr(8'h0a, 8'h33, 1'b1);
      chk(8'(blk), 8'h01, "drop flag");
      rd(8'h0a, 8'h5a, "dropped");
      fwd_req = 1'b1;
      tick();
      chk(8'(fwd_go), 8'h01, "forward");
      fwd_req = 1'b0;
      tick();
      wr(8'h08, 8'h1c, 1'b0);
      wr(8'h0a, 8'h33, 1'b1);
      rd(8'h0a, 8'h33, "kept");
   endtask
   // one controller clock with short counts
   task automatic t_ctl();
      int n;
      wr(8'h0a, 8'h02, 1'b0);
      wr(8'h0b, 8'h03, 1'b0);
      ctl_pulse_req = 1'b1;
      tick();
      ctl_pulse_req = 1'b0;
      for (n = 0; n < 20 && scl_oe !== 1'b1; n++)
         tick();
      chk({6'h00, scl_out, sda_out}, 8'h00, "pin drive level");
      for (n = 0; n < 100 && scl_oe === 1'b1; n++)
         tick();
      chk_n(n, 2 * (3 + 5) - 1, 2 * (3 + 5) + 1, "low phase");
      for (n = 0; n < 100 && ctl_done !== 1'b1; n++)
         tick();
      chk_n(n, 2 * (2 + 5) - 1, 2 * (2 + 5) + 2, "high phase");
   endtask
   // sda output delay for every code, watchdog off
   task automatic t_sda_out();
      int n;
      int c;
      for (c = 0; c < 4; c++)
      begin
         wr(8'h09, {4'h1, c[1:0], 2'b01}, 1'b0);
         tgt_sda_low = !c[0];
         ext_scl = 1'b1;
         for (n = 0; n < 20 && scl_filt !== 1'b0; n++)
            tick();
         for (n = 0; n < 40 && sda_oe !== tgt_sda_low; n++)
            tick();
         chk_n(n, 11 + 2 * c, 13 + 2 * c, "sda delay");
         ext_scl = 1'b0;
         repeat (10) tick();
      end
   endtask
   // stretch release: low count, then remote ack setup 1
   task automatic t_stretch();
      int n;
      int e;
      for (int k = 0; k < 2; k++)
      begin
         e = k ? (80 + 640 + 19) / 20 : 2 * (3 + 5);
         tgt_remote_ack = (k != 0);
         tgt_stretch = 1'b1;
         ext_scl = 1'b1;
         for (n = 0; n < 20 && scl_oe !== 1'b1; n++)
            tick();
         ext_scl = 1'b0;
         repeat (4) tick();
         tgt_stretch = 1'b0;
         for (n = 0; n < 600 && scl_oe === 1'b1; n++)
            tick();
         chk_n(n, e - 1, e + 2, "stretch");
         repeat (10) tick();
      end
   endtask
   // watchdog off, fast, slow, then hung-bus recovery
   task automatic t_wd();
      int n;
      int e;
      int p;
      logic prev;
      repeat (3000) tick();
      chk(8'(bus_free), 8'h00, "free when off");
      for (int k = 0; k < 2; k++)
      begin
         e = k ? WD_SLOW : 50000 / 20;
         wr(8'h09, k ? 8'h00 : 8'h02, 1'b0);
         ext_scl = 1'b1;
         repeat (8) tick();
         ext_scl = 1'b0;
         for (n = 0; n < 3000 && bus_free !== 1'b1; n++)
            tick();
         chk_n(n, e - 5, e + 15, "watchdog");
      end
      ext_sda = 1'b1;
      for (n = 0; n < 400 && bus_recovering !== 1'b1; n++)
         tick();
      chk_n(n, WD_SLOW, WD_SLOW + 40, "recovery start");
      p = 0;
      prev = 1'b0;
      for (n = 0; n < 2000 && ctl_done !== 1'b1; n++)
      begin
         if (scl_oe === 1'b1 && prev !== 1'b1)
            p++;
         prev = scl_oe;
         tick();
      end
      chk_n(p, 9, 9, "recovery pulses");
      ext_sda = 1'b0;
      repeat (20) tick();
   endtask
   // glitch at the filter width, then hold of 1 against 4 units
   task automatic t_filt_hold();
      int n;
      int d [2];
      logic g;
      wr(8'h09, 8'h01, 1'b0);
      {ext_scl, ext_sda} = 2'b11;
      repeat (3) tick();
      {ext_scl, ext_sda} = 2'b00;
      g = 1'b1;
      repeat (20)
      begin
         g = g & scl_filt & sda_held;
         tick();
      end
      chk(8'(g), 8'h01, "glitch");
      for (int k = 0; k < 2; k++)
      begin
         wr(8'h08, k ? 8'h4c : 8'h1c, 1'b0);
         ext_sda = 1'b1;
         for (n = 0; n < 60 && sda_held !== 1'b0; n++)
            tick();
         d[k] = n;
         ext_sda = 1'b0;
         repeat (40) tick();
      end
      n = (4 * 50 + 19) / 20 - (50 + 19) / 20;
      chk_n(d[1] - d[0], n, n, "hold step");
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // reset for 4 cycles, then the scenarios
   initial
   begin
      {srst, reg_wr, reg_rd, reg_remote, fwd_req, tgt_sda_low, tgt_stretch, tgt_remote_ack} = 8'h80;
      {ctl_pulse_req, ext_scl, ext_sda} = 3'b000;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (4) @(posedge core_clk);
      #1;
      srst = 1'b0;
      t_regs();
      t_block();
      t_ctl();
      t_sda_out();
      t_stretch();
      t_wd();
      t_filt_hold();
      print_verdict();
   end
endmodule // tb_i2c_port_timing_config
